/* File: rtl/timer_regs.vh */
// Register map, field positions and timing constants of the timer block
`ifndef TIMER_REGS_VH
`define TIMER_REGS_VH
`define OFF_CONFIG 8'h8C
`define OFF_COUNT 8'h90
`define OFF_FREE_RUN 8'h9C
`define OFF_FREE_HIGH 8'hA0
`define OFF_INT_STATUS 8'hB0
`define OFF_INT_ENABLE 8'hB4
`define OFF_INT_CLEAR 8'hB8
`define OFF_POWER 8'hBC
`define RUN_BIT 29
`define LOAD_MSB 15
`define PRELOAD_RESET 16'hFFFF
`define COUNT_RESET 16'hFFFF
`define COUNT_ZERO 16'h0000
`define FREE_RESET 32'h00000000
`define FREE_ONE 32'h00000001
`define CLK_PERIOD_PS 8000
`define TICK_PERIOD_PS 40000
`define TICK_DIV_CYCLES ((`TICK_PERIOD_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CLEAR_TIME_NS 160
`define CLEAR_CYCLES ((`CLEAR_TIME_NS * 1000) / `CLK_PERIOD_PS)
`define DIV_WIDTH 3
`define DIV_ONE 3'h1
`define DIV_ZERO 3'h0
`define DIV_LAST 3'h4
`define INT_BITS 2
`define INT_TIMER 0
`define INT_WRAP 1
`define POWER_BITS 2
`endif

/* File: rtl/free_run_counter.v */
// Free-running 32-bit counter advancing once per 25 MHz tick
`include "timer_regs.vh"
`default_nettype none
module free_run_counter (
  input wire pclk,
  input wire presetn,
  input wire ce,
  output reg [31:0] free_running_tick_count,
  output reg wrap_pulse
);
  reg [`DIV_WIDTH-1:0] div;
  // Five pclk cycles make one 25 MHz tick
  wire tick = (div == `DIV_LAST);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= `DIV_ZERO;
      free_running_tick_count <= `FREE_RESET;
      wrap_pulse <= 1'b0;
    end else if (ce) begin
      wrap_pulse <= 1'b0;
      if (tick) begin
        div <= `DIV_ZERO;
        // Wraps to zero naturally on overflow
        free_running_tick_count <= free_running_tick_count + `FREE_ONE;
        wrap_pulse <= &free_running_tick_count;
      end else begin
        div <= div + `DIV_ONE;
      end
    end
  end
endmodule
`default_nettype wire

/* File: rtl/general_timer.v */
// APB general-purpose timer with free-running counter and interrupts
//
// Operation
// - Run-enable bit set runs the timer; cleared halts it.
// - Falling run-enable forces preload field to FFFFh.
// - Software-written 16-bit preload loads the timer; resets to FFFFh.
// - Read-only live count shows timer value; FFFFh after reset.
// - Timer raises interrupts at intervals set by the preload.
// - 32-bit free counter starts at zero, advances each 25 MHz tick.
// - Free counter wraps from maximum to zero and continues.
// - First read latches free count so both halves agree.
// - Free counter may take up to 160 ns to read zero after reset.
// - Free counter runs in power states D0, D1 and D2.
//
// Local design decision: the APB slave port.
`include "timer_regs.vh"
`default_nettype none
module general_timer (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire irq
);
  reg run_enable;
  reg [15:0] preload_value;
  reg [15:0] live_count;
  reg [31:0] free_latch;
  reg [`INT_BITS-1:0] int_status;
  reg [`INT_BITS-1:0] int_enable;
  reg [`POWER_BITS-1:0] power_state;
  reg [31:0] next_prdata;
  reg [`INT_BITS-1:0] set_bits;
  reg [`INT_BITS-1:0] clr_bits;
  wire [31:0] free_running_tick_count;
  wire wrap_pulse;
  wire access = psel & penable;
  wire wr = access & pwrite;
  wire rd = access & ~pwrite;
  wire timer_zero = run_enable & (live_count == `COUNT_ZERO);

  function hit;
    input [7:0] a;
    input [7:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  function mapped;
    input [7:0] a;
    begin
      mapped = hit(a, `OFF_CONFIG) | hit(a, `OFF_COUNT) | hit(a, `OFF_FREE_RUN) |
        hit(a, `OFF_FREE_HIGH) | hit(a, `OFF_INT_STATUS) | hit(a, `OFF_INT_ENABLE) |
        hit(a, `OFF_INT_CLEAR) | hit(a, `OFF_POWER);
    end
  endfunction

  // Zero-wait slave; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access & ~mapped(paddr);
  assign irq = |(int_status & int_enable);

  // Power state is only observed: the free counter never stops in it
  free_run_counter u_free (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .free_running_tick_count(free_running_tick_count),
    .wrap_pulse(wrap_pulse)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_enable <= 1'b0;
      preload_value <= `PRELOAD_RESET;
      power_state <= {`POWER_BITS{1'b0}};
      int_enable <= {`INT_BITS{1'b0}};
    end else if (ce) begin
      if (wr && hit(paddr, `OFF_CONFIG)) begin
        if (pstrb[3])
          run_enable <= pwdata[`RUN_BIT];
        if (pstrb[3] && run_enable && !pwdata[`RUN_BIT])
          preload_value <= `PRELOAD_RESET;
        else if (pstrb[1:0] == 2'h3)
          preload_value <= pwdata[`LOAD_MSB:0];
      end
      if (wr && hit(paddr, `OFF_INT_ENABLE) && pstrb[0])
        int_enable <= pwdata[`INT_BITS-1:0];
      if (wr && hit(paddr, `OFF_POWER) && pstrb[0])
        power_state <= pwdata[`POWER_BITS-1:0];
    end
  end

  // Down counter; holds its value while halted
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      live_count <= `COUNT_RESET;
    end else if (ce) begin
      if (run_enable) begin
        if (live_count == `COUNT_ZERO)
          live_count <= preload_value;
        else
          live_count <= live_count - 16'h0001;
      end
    end
  end

  // Sticky status: a new event wins over a same-cycle clear
  always @* begin
    set_bits = {`INT_BITS{1'b0}};
    set_bits[`INT_TIMER] = timer_zero;
    set_bits[`INT_WRAP] = wrap_pulse;
    clr_bits = {`INT_BITS{1'b0}};
    if (wr && hit(paddr, `OFF_INT_CLEAR) && pstrb[0])
      clr_bits = pwdata[`INT_BITS-1:0];
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      int_status <= {`INT_BITS{1'b0}};
    else if (ce)
      int_status <= (int_status & ~clr_bits) | set_bits;
  end

  // Capture on the same setup edge as prdata, so both halves agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      free_latch <= `FREE_RESET;
    else if (ce && psel && !penable && !pwrite && hit(paddr, `OFF_FREE_RUN))
      free_latch <= free_running_tick_count;
  end

  always @* begin
    next_prdata = 32'h00000000;
    if (hit(paddr, `OFF_CONFIG))
      next_prdata = {2'h0, run_enable, 13'h0000, preload_value};
    else if (hit(paddr, `OFF_COUNT))
      next_prdata = {16'h0000, live_count};
    else if (hit(paddr, `OFF_FREE_RUN))
      next_prdata = free_running_tick_count;
    else if (hit(paddr, `OFF_FREE_HIGH))
      next_prdata = free_latch;
    else if (hit(paddr, `OFF_INT_STATUS))
      next_prdata = {30'h00000000, int_status};
    else if (hit(paddr, `OFF_INT_ENABLE))
      next_prdata = {30'h00000000, int_enable};
    else if (hit(paddr, `OFF_POWER))
      next_prdata = {30'h00000000, power_state};
  end

  // Data registered in setup so it is stable throughout the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (ce && psel && !penable && !pwrite)
      prdata <= next_prdata;
  end
endmodule
`default_nettype wire

/* File: bench/general_timer_sva.sv */
// Port checks for the general timer
`default_nettype none
module general_timer_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire ac = psel && penable;
  wire rq = ac && !pwrite;
  property p_rdy; pready; endproperty
  a_rdy: assert property (p_rdy) else $error("wait state");
  property p_err; pslverr |-> ac; endproperty
  a_err: assert property (p_err) else $error("stray error");
  property p_unm; ac && paddr == 8'h84 |-> pslverr; endproperty
  a_unm: assert property (p_unm) else $error("hole accepted");
  property p_map; ac && paddr == 8'h90 |-> !pslverr; endproperty
  a_map: assert property (p_map) else $error("count refused");
  property p_erz; rq && pslverr |-> prdata == 32'h0; endproperty
  a_erz: assert property (p_erz) else $error("hole data");
  property p_cnt; rq && paddr == 8'h90 |-> prdata[31:16] == 16'h0; endproperty
  a_cnt: assert property (p_cnt) else $error("count top");
  property p_cfg; rq && paddr == 8'h8C |-> prdata[31:30] == 2'h0 && prdata[28:16] == 13'h0; endproperty
  a_cfg: assert property (p_cfg) else $error("config spare");
  property p_clr; rq && paddr == 8'hB8 |-> prdata == 32'h0; endproperty
  a_clr: assert property (p_clr) else $error("clear read");
endmodule
bind general_timer general_timer_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

/* File: bench/general_timer_tb_top.sv */
// Self-checking timer bench
`default_nettype none
module general_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, fr, all = 32'hFFFFFFFF, lfsr = 32'h8371817E;
  logic [63:0] q[$];
  int n_fail = 0, checked = 0, cyc = 0, c0, t0, t1, p;
  always #4 pclk = ~pclk;
  general_timer u_general_timer (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tally_and_finish;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Zero mask leaves the read to the caller
  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d, e = 32'h0, m = 32'h0);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    if (!w) q.push_back({m, e});
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {rd, c0} = {prdata, cyc};
    {psel, penable} <= 2'h0;
    @(posedge pclk);
  endtask
  // Falling edge sample avoids racing the status update
  task automatic wait_irq;
    do @(negedge pclk); while (irq !== 1'b1);
    t0 = cyc;
    @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (psel && penable && !pwrite && pready === 1'b1 && q.size() > 0) begin
      if (q[0][63:32] != 32'h0) check("prdata", prdata & q[0][63:32], q[0][31:0]);
      void'(q.pop_front());
    end
    if (cyc == 90000) begin
      n_fail++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    xf(1'b0, 8'h8C, 32'h0, 32'hFFFF, all);
    xf(1'b0, 8'h90, 32'h0, 32'hFFFF, all);
    xf(1'b0, 8'h84, 32'h0, 32'h0, all);
    xf(1'b0, 8'hB8, 32'h0, 32'h0, all);
    xf(1'b0, 8'h9C, 32'h0);
    {fr, t1} = {rd, c0};
    xf(1'b0, 8'hA0, 32'h0, rd, all);
    xf(1'b1, 8'hBC, 32'h2);
    xf(1'b0, 8'h9C, 32'h0);
    check("free step", (rd - fr) * 5 + 5 > c0 - t1 && (rd - fr) * 5 < c0 - t1 + 5, 32'h1);
    $display("reset and free counter done");
    lfsr = nxt(lfsr);
    p = 16 + lfsr[5:0];
    xf(1'b1, 8'h8C, 32'h20000000 | p);
    xf(1'b1, 8'hB4, 32'h1);
    wait_irq;
    t1 = t0;
    xf(1'b1, 8'hB8, 32'h1);
    wait_irq;
    check("irq period", t0 - t1, p + 1);
    xf(1'b1, 8'hB4, 32'h0);
    check("irq masked", irq, 32'h0);
    xf(1'b1, 8'h8C, 32'h1234);
    xf(1'b0, 8'h8C, 32'h0, 32'hFFFF, all);
    $display("timer done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
